// [port_conditioning.sv]
`timescale 1ns/1ps
// Operation
// - six ports, each input only, push-pull output or open-drain output
// - open-drain ports drive and keep their input chain running
// - reset: input drive, no inversion, pass-through, 3000 ohm, 1.65 V level
// - each port holds a threshold level code; comparator high only above it
// - input chain may invert the comparator result; off by default
// - input chain may resample on the reference clock; bypassed by default
// - port 1 raw input may go straight to the backplane sync tap
// - output driver follows drive selection; disabled when input selected
// - output chain may invert the signal before driving; off by default
// - output source: pass-through, registered, or pulse; pass-through default
// - pulse mode emits one pulse per rising edge seen while no pulse runs, none on falling
// - pulse width fixed, within 80 to 160 ns
// - output inversion applies after pulse generation
// - trigger route clear forces every output source to pass-through
// - sync tap carries port 1 connector input or port 1 output chain
// - no separate enable; drive selection changes act at once
// - output settings reach the pin only in push-pull or open-drain
// - unassigned crosspoint outputs present constant zero to the port
module port_conditioning #(
  parameter int PORTS = port_cond_pkg::PORT_COUNT
) (
  input  wire logic                                     ref_clk_in,
  input  wire logic                                     sys_rst_in,
  input  wire logic [7:0]                               reg_addr_in,
  input  wire logic [31:0]                              reg_wdata_in,
  input  wire logic                                     reg_wr_in,
  input  wire logic                                     reg_rd_in,
  output logic      [31:0]                              reg_rdata_out,
  input  wire logic [PORTS-1:0]                         comparator_hit_in,
  input  wire logic [PORTS-1:0]                         pin_in,
  output logic      [PORTS-1:0]                         pin_out,
  output logic      [PORTS-1:0]                         pin_oe_out,
  input  wire logic [PORTS-1:0]                         xp_port_in,
  output logic      [PORTS-1:0]                         xp_port_out,
  output logic                                          first_port_sync_tap_out,
  output logic      [PORTS*port_cond_pkg::LEVEL_W-1:0]  comparator_level_out,
  output logic      [PORTS-1:0]                         termination_select_out
);
  import port_cond_pkg::*;

  // per-port word address, shared by the write and read decoders
  function automatic logic [7:0] word_off(input logic [7:0] base, input int p);
    return base + 8'(4 * p);
  endfunction

  // per-port config state
  drive_t                   drive_q [PORTS];
  out_src_t                 src_q [PORTS];
  logic [PORTS-1:0]         in_inv_q;
  logic [PORTS-1:0]         resync_q;
  logic [PORTS-1:0]         out_inv_q;
  logic [PORTS-1:0]         term_q;
  logic [PORTS*LEVEL_W-1:0] level_q;
  // shared controls, read path and chain taps
  logic                     tap_src_q;
  logic [31:0]              rd_d;
  logic [31:0]              rdata_q;
  logic [PORTS-1:0]         chain;
  logic                     route_clear;

  assign route_clear = reg_wr_in && reg_addr_in == ROUTE_CLEAR_OFF
                       && reg_wdata_in[ROUTE_CLR_BIT];

  // port config words; the route clear is applied last so it wins
  always_ff @(posedge ref_clk_in) begin
    for (int p = 0; p < PORTS; p++) begin
      if (sys_rst_in) begin
        drive_q[p]   <= DRIVE_RESET;
        src_q[p]     <= SRC_RESET;
        in_inv_q[p]  <= IN_INV_RESET;
        resync_q[p]  <= RESYNC_RESET;
        out_inv_q[p] <= OUT_INV_RESET;
        term_q[p]    <= TERM_RESET;
      end else begin
        if (reg_wr_in && reg_addr_in == word_off(CFG_BASE, p)) begin
          drive_q[p]   <= drive_t'(reg_wdata_in[CFG_DRIVE_LSB +: 2]);
          in_inv_q[p]  <= reg_wdata_in[CFG_IN_INV];
          resync_q[p]  <= reg_wdata_in[CFG_IN_RESYNC];
          out_inv_q[p] <= reg_wdata_in[CFG_OUT_INV];
          src_q[p]     <= out_src_t'(reg_wdata_in[CFG_SRC_LSB +: 2]);
          term_q[p]    <= reg_wdata_in[CFG_TERM];
        end
        if (route_clear) begin
          src_q[p] <= SRC_PASS;
        end
      end
    end
  end

  // threshold codes go straight to the per-port level dacs
  always_ff @(posedge ref_clk_in) begin
    for (int p = 0; p < PORTS; p++) begin
      if (sys_rst_in) begin
        level_q[p*LEVEL_W +: LEVEL_W] <= LEVEL_RESET;
      end else if (reg_wr_in && reg_addr_in == word_off(LEVEL_BASE, p)) begin
        level_q[p*LEVEL_W +: LEVEL_W] <= reg_wdata_in[LEVEL_W-1:0];
      end
    end
  end

  // sync tap source select
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      tap_src_q <= TAP_SRC_RESET;
    end else if (reg_wr_in && reg_addr_in == TAP_CTRL_OFF) begin
      tap_src_q <= reg_wdata_in[TAP_SRC_BIT];
    end
  end

  // read mux; unmapped addresses and write-only words read zero
  always_comb begin
    rd_d = 32'h0;
    for (int p = 0; p < PORTS; p++) begin
      if (reg_addr_in == word_off(CFG_BASE, p)) begin
        rd_d[CFG_DRIVE_LSB +: 2] = drive_q[p];
        rd_d[CFG_IN_INV]         = in_inv_q[p];
        rd_d[CFG_IN_RESYNC]      = resync_q[p];
        rd_d[CFG_OUT_INV]        = out_inv_q[p];
        rd_d[CFG_SRC_LSB +: 2]   = src_q[p];
        rd_d[CFG_TERM]           = term_q[p];
      end
      if (reg_addr_in == word_off(LEVEL_BASE, p)) begin
        rd_d[LEVEL_W-1:0] = level_q[p*LEVEL_W +: LEVEL_W];
      end
    end
    if (reg_addr_in == TAP_CTRL_OFF) begin
      rd_d[TAP_SRC_BIT] = tap_src_q;
    end
    if (reg_addr_in == STATUS_OFF) begin
      rd_d[STAT_XP_LSB +: PORTS]  = xp_port_out;
      rd_d[STAT_PIN_LSB +: PORTS] = pin_out;
      rd_d[STAT_OE_LSB +: PORTS]  = pin_oe_out;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= reg_rd_in ? rd_d : 32'h0;
    end
  end

  assign reg_rdata_out          = rdata_q;
  assign comparator_level_out   = level_q;
  assign termination_select_out = term_q;

  // comparator result arrives already sliced against the level code
  port_input_chain #(
    .PORTS (PORTS)
  ) u_in (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .hit_in     (comparator_hit_in),
    .invert_in  (in_inv_q),
    .resync_in  (resync_q),
    .xp_out     (xp_port_out)
  );

  // an unrouted crosspoint output arrives here as a steady zero
  port_output_chain #(
    .PORTS (PORTS)
  ) u_out (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .xp_in      (xp_port_in),
    .src_in     (src_q),
    .drive_in   (drive_q),
    .invert_in  (out_inv_q),
    .chain_out  (chain),
    .pin_out    (pin_out),
    .pin_oe_out (pin_oe_out)
  );

  // raw connector path skips comparator, polarity and flip-flop
  assign first_port_sync_tap_out = tap_src_q ? chain[0] : pin_in[0];

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  // first cycle out of reset shows the defaults
  reset_defaults_a: assert property (
    $fell(sys_rst_in) |-> pin_oe_out == '0 && tap_src_q == 1'b0
      && comparator_level_out[LEVEL_W-1:0] == LEVEL_RESET && src_q[0] == SRC_PASS)
    else $error("reset defaults wrong");

  // drive change acts with no commit step
  drive_write_a: assert property (
    reg_wr_in && reg_addr_in == CFG_BASE
      && reg_wdata_in[CFG_DRIVE_LSB +: 2] == 2'h1
    |=> drive_q[0] == DRIVE_PUSH_PULL && pin_oe_out[0])
    else $error("drive change not immediate");

  // spare drive code keeps the pin released
  drive_three_a: assert property (
    drive_q[5] == drive_t'(2'h3) |-> !pin_oe_out[5] && !pin_out[5])
    else $error("spare drive code drives pin");

  // level code lands in one write
  level_write_a: assert property (
    reg_wr_in && reg_addr_in == word_off(LEVEL_BASE, 2)
    |=> comparator_level_out[2*LEVEL_W +: LEVEL_W] == $past(reg_wdata_in[LEVEL_W-1:0]))
    else $error("level code not stored");

  // termination follows its config bit
  term_write_a: assert property (
    reg_wr_in && reg_addr_in == word_off(CFG_BASE, 5)
    |=> termination_select_out[5] == $past(reg_wdata_in[CFG_TERM]))
    else $error("termination select not stored");

  // clear reaches every port, first and last
  route_clear_a: assert property (
    route_clear |=> src_q[0] == SRC_PASS && src_q[PORTS-1] == SRC_PASS)
    else $error("route clear left output mode");

  // raw connector path on the tap
  tap_raw_a: assert property (
    !tap_src_q |-> first_port_sync_tap_out == pin_in[0])
    else $error("sync tap not raw port input");

  // output chain path on the tap
  tap_chain_a: assert property (
    tap_src_q && drive_q[0] == DRIVE_PUSH_PULL |-> first_port_sync_tap_out == pin_out[0])
    else $error("sync tap not output chain");

  // tap source follows its control bit
  tap_ctrl_a: assert property (
    reg_wr_in && reg_addr_in == TAP_CTRL_OFF
    |=> tap_src_q == $past(reg_wdata_in[TAP_SRC_BIT]))
    else $error("tap source not stored");

  // open-drain ports keep listening
  od_listen_a: assert property (
    drive_q[5] == DRIVE_OPEN_DRAIN && !resync_q[5]
    |-> xp_port_out[5] == (comparator_hit_in[5] ^ in_inv_q[5]))
    else $error("open drain input chain idle");

  // open drain lets go while the chain is high
  od_release_a: assert property (
    drive_q[5] == DRIVE_OPEN_DRAIN && src_q[5] == SRC_PASS
    |-> pin_oe_out[5] == !(xp_port_in[5] ^ out_inv_q[5]) && !pin_out[5])
    else $error("open drain level wrong");

  // bypassed input is not delayed
  in_bypass_a: assert property (
    !resync_q[1] |-> xp_port_out[1] == (comparator_hit_in[1] ^ in_inv_q[1]))
    else $error("bypassed input delayed");

  // settings unused on an input port
  out_unused_a: assert property (
    drive_q[2] == DRIVE_INPUT |-> !pin_oe_out[2] && !pin_out[2])
    else $error("output settings reach input pin");

  // pass-through with optional polarity
  pass_out_a: assert property (
    src_q[2] == SRC_PASS && drive_q[2] == DRIVE_PUSH_PULL
    |-> pin_out[2] == (xp_port_in[2] ^ out_inv_q[2]))
    else $error("pass output polarity wrong");

  // registered source lags by one edge
  registered_out_a: assert property (
    src_q[2] == SRC_REGISTERED && $stable(src_q[2]) && drive_q[2] == DRIVE_PUSH_PULL
      && !out_inv_q[2] && $stable(out_inv_q[2])
    |-> pin_out[2] == $past(xp_port_in[2]))
    else $error("registered output not one cycle late");

  // pulse on the pin spans 80 to 160 ns
  pulse_pin_a: assert property (
    src_q[3] == SRC_PULSE && drive_q[3] == DRIVE_PUSH_PULL && !out_inv_q[3]
      && $rose(pin_out[3])
    |-> pin_out[3] [*8] ##1 pin_out[3] [*2] ##[1:11] !pin_out[3])
    else $error("pin pulse width out of range");

  // falling crosspoint edge leaves the pin low
  pulse_fall_a: assert property (
    src_q[3] == SRC_PULSE && drive_q[3] == DRIVE_PUSH_PULL && !out_inv_q[3]
      && $fell(xp_port_in[3]) && !pin_out[3]
    |=> !pin_out[3])
    else $error("pulse on falling crosspoint edge");

  // status enables match the pins
  read_status_a: assert property (
    reg_rd_in && reg_addr_in == STATUS_OFF
    |=> reg_rdata_out[STAT_OE_LSB +: PORTS] == $past(pin_oe_out))
    else $error("status read mismatch");

  // status levels match the pins and chains
  status_pins_a: assert property (
    reg_rd_in && reg_addr_in == STATUS_OFF
    |=> reg_rdata_out[STAT_PIN_LSB +: PORTS] == $past(pin_out)
      && reg_rdata_out[STAT_XP_LSB +: PORTS] == $past(xp_port_out))
    else $error("status pin fields wrong");

  // main scenarios reached
  pulse_seen_c: cover property (
    src_q[3] == SRC_PULSE && $rose(chain[3]) ##10 $fell(chain[3]));
  od_mode_c: cover property (drive_q[5] == DRIVE_OPEN_DRAIN && pin_oe_out[5]);
  tap_chain_c: cover property (tap_src_q && $rose(first_port_sync_tap_out));
  route_clear_c: cover property (src_q[4] == SRC_PULSE ##1 route_clear);
  term_sel_c: cover property (termination_select_out[5] && drive_q[5] == drive_t'(2'h3));
endmodule // port_conditioning

// [port_cond_pkg.sv]
package port_cond_pkg;
  // port count and comparator level width
  localparam int PORT_COUNT = 6;
  localparam int LEVEL_W    = 12;

  // pin driver selection and output-chain source
  typedef enum logic [1:0] {DRIVE_INPUT, DRIVE_PUSH_PULL, DRIVE_OPEN_DRAIN} drive_t;
  typedef enum logic [1:0] {SRC_PASS, SRC_REGISTERED, SRC_PULSE} out_src_t;

  // register byte offsets; per-port words step by four
  localparam logic [7:0] CFG_BASE        = 8'h00;
  localparam logic [7:0] LEVEL_BASE      = 8'h20;
  localparam logic [7:0] TAP_CTRL_OFF    = 8'h40;
  localparam logic [7:0] ROUTE_CLEAR_OFF = 8'h44;
  localparam logic [7:0] STATUS_OFF      = 8'h48;

  // port config, tap control, route clear and status word fields
  localparam int CFG_DRIVE_LSB  = 0;
  localparam int CFG_IN_INV     = 2;
  localparam int CFG_IN_RESYNC  = 3;
  localparam int CFG_OUT_INV    = 4;
  localparam int CFG_SRC_LSB    = 5;
  localparam int CFG_TERM       = 7;
  localparam int TAP_SRC_BIT    = 0;
  localparam int ROUTE_CLR_BIT  = 0;
  localparam int STAT_XP_LSB    = 0;
  localparam int STAT_PIN_LSB   = 8;
  localparam int STAT_OE_LSB    = 16;

  // reset values; level code = round((volts + 5) / 10 * 4096), 1.65 V
  localparam drive_t         DRIVE_RESET   = DRIVE_INPUT;
  localparam out_src_t       SRC_RESET     = SRC_PASS;
  localparam logic           IN_INV_RESET  = 1'b0;
  localparam logic           RESYNC_RESET  = 1'b0;
  localparam logic           OUT_INV_RESET = 1'b0;
  localparam logic           TERM_RESET    = 1'b0;
  localparam logic           TAP_SRC_RESET = 1'b0;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 12'haa4;

  // pulse timing at the 125 MHz clock
  localparam int CLK_MHZ          = 125;
  localparam int PULSE_MIN_NS     = 80;
  localparam int PULSE_MAX_NS     = 160;
  localparam int PULSE_CYCLES     = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_MAX_CYCLES = (PULSE_MAX_NS * CLK_MHZ) / 1000;
  localparam int PULSE_CNT_W      = 5;
endpackage

// [port_input_chain.sv]
`timescale 1ns/1ps
module port_input_chain #(
  parameter int PORTS = port_cond_pkg::PORT_COUNT
) (
  input  wire logic             ref_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [PORTS-1:0] hit_in,
  input  wire logic [PORTS-1:0] invert_in,
  input  wire logic [PORTS-1:0] resync_in,
  output logic      [PORTS-1:0] xp_out
);
  import port_cond_pkg::*;

  logic [PORTS-1:0] cond;
  logic [PORTS-1:0] resync_q;

  // polarity first, so the flip-flop samples the conditioned level
  assign cond = hit_in ^ invert_in;

  // resync stage runs always; only the select decides whether it is used
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      resync_q <= '0;
    end else begin
      resync_q <= cond;
    end
  end

  // chain stays live in every drive mode, so open-drain ports also listen
  assign xp_out = (resync_in & resync_q) | (~resync_in & cond);

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  in_polarity_a: assert property (
    (resync_in[0] == 1'b0) |-> (xp_out[0] == (hit_in[0] ^ invert_in[0])))
    else $error("input polarity path wrong");
  in_resync_a: assert property (
    resync_in[1] && $past(resync_in[1]) |-> (xp_out[1] == $past(cond[1])))
    else $error("resync path not one cycle late");
endmodule // port_input_chain

// [port_output_chain.sv]
`timescale 1ns/1ps
module port_output_chain #(
  parameter int PORTS = port_cond_pkg::PORT_COUNT
) (
  input  wire logic                   ref_clk_in,
  input  wire logic                   sys_rst_in,
  input  wire logic     [PORTS-1:0]   xp_in,
  input  port_cond_pkg::out_src_t     src_in [PORTS],
  input  port_cond_pkg::drive_t       drive_in [PORTS],
  input  wire logic     [PORTS-1:0]   invert_in,
  output logic          [PORTS-1:0]   chain_out,
  output logic          [PORTS-1:0]   pin_out,
  output logic          [PORTS-1:0]   pin_oe_out
);
  import port_cond_pkg::*;

  logic [PORTS-1:0]   reg_q;
  logic [PORTS-1:0]   prev_q;
  logic [PULSE_CNT_W-1:0] cnt_q [PORTS];
  logic [PORTS-1:0]   rise;
  logic [PORTS-1:0]   pulse;

  assign rise = xp_in & ~prev_q;

  // registered copy and edge history; edges during a pulse are absorbed
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      reg_q  <= '0;
      prev_q <= '0;
    end else begin
      reg_q  <= xp_in;
      prev_q <= xp_in;
    end
  end

  // fixed-width pulse counter, loaded on a rising edge only while idle
  always_ff @(posedge ref_clk_in) begin
    for (int p = 0; p < PORTS; p++) begin
      if (sys_rst_in) begin
        cnt_q[p] <= '0;
      end else if (rise[p] && cnt_q[p] == '0) begin
        cnt_q[p] <= PULSE_CNT_W'(PULSE_CYCLES);
      end else if (cnt_q[p] != '0) begin
        cnt_q[p] <= cnt_q[p] - 1'b1;
      end
    end
  end

  // source select, polarity after the pulse, then the driver
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      pulse[p] = (cnt_q[p] != '0);
      case (src_in[p])
        SRC_REGISTERED: chain_out[p] = reg_q[p] ^ invert_in[p];
        SRC_PULSE:      chain_out[p] = pulse[p] ^ invert_in[p];
        default:        chain_out[p] = xp_in[p] ^ invert_in[p];
      endcase
      case (drive_in[p])
        DRIVE_PUSH_PULL: begin
          pin_out[p]    = chain_out[p];
          pin_oe_out[p] = 1'b1;
        end
        DRIVE_OPEN_DRAIN: begin
          pin_out[p]    = 1'b0;
          pin_oe_out[p] = ~chain_out[p];
        end
        default: begin
          pin_out[p]    = 1'b0;
          pin_oe_out[p] = 1'b0;
        end
      endcase
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  pulse_load_a: assert property (
    rise[0] && cnt_q[0] == '0 |=> cnt_q[0] == PULSE_CNT_W'(PULSE_CYCLES))
    else $error("pulse not started on rising edge");
  pulse_width_a: assert property (
    $rose(pulse[3]) |-> pulse[3] [*8] ##1 pulse[3] [*2] ##[1:11] !pulse[3])
    else $error("pulse width out of range");
  fall_no_pulse_a: assert property (
    $fell(xp_in[3]) && cnt_q[3] == '0 |=> cnt_q[3] == '0)
    else $error("pulse on falling edge");
  input_no_drive_a: assert property (
    drive_in[1] == DRIVE_INPUT |-> pin_oe_out[1] == 1'b0)
    else $error("input port driving");
  od_drive_a: assert property (
    drive_in[5] == DRIVE_OPEN_DRAIN |-> pin_out[5] == 1'b0 && pin_oe_out[5] == ~chain_out[5])
    else $error("open drain drives high");
  pulse_invert_a: assert property (
    src_in[3] == SRC_PULSE && invert_in[3] && cnt_q[3] == '0 |-> chain_out[3] == 1'b1)
    else $error("inversion not after pulse");
endmodule // port_output_chain

// [front_panel_far_end.sv]
`timescale 1ns/1ps
// instruments at the connectors; the pin is a wired line with a pull-up
module front_panel_far_end (
  input  wire logic [5:0] pin_out_in,
  input  wire logic [5:0] pin_oe_in,
  input  wire logic [5:0] ext_en_in,
  input  wire logic [5:0] ext_val_in,
  output logic      [5:0] pin_in_out,
  output logic      [5:0] hit_out
);
  // module drive wins, else an instrument, else the pull-up lifts the line
  always_comb begin
    for (int p = 0; p < 6; p++) begin
      pin_in_out[p] = pin_oe_in[p] ? pin_out_in[p] : (ext_en_in[p] ? ext_val_in[p] : 1'b1);
    end
  end
  // comparator at its default level sees 3.3 V as high, 0 V as low
  assign hit_out = pin_in_out;
endmodule // front_panel_far_end

// [programmable_port_conditioning_tb_top.sv]
`timescale 1ns/1ps
module programmable_port_conditioning_tb_top;
  import port_cond_pkg::*;
  logic        ref_clk_in;
  logic        sys_rst_in;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [5:0]  hit;
  logic [5:0]  pin_in;
  logic [5:0]  pin_out;
  logic [5:0]  pin_oe;
  logic [5:0]  xp_in;
  logic [5:0]  xp_out;
  logic        tap;
  logic [71:0] levels;
  logic [5:0]  term;
  logic [5:0]  ext_en;
  logic [5:0]  ext_val;
  logic [31:0] rv;
  int          errors;
  int          total_checks;
  int          cyc;

  port_conditioning dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .comparator_hit_in(hit), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_out(pin_oe), .xp_port_in(xp_in), .xp_port_out(xp_out),
    .first_port_sync_tap_out(tap), .comparator_level_out(levels),
    .termination_select_out(term));
  front_panel_far_end far (.pin_out_in(pin_out), .pin_oe_in(pin_oe), .ext_en_in(ext_en),
    .ext_val_in(ext_val), .pin_in_out(pin_in), .hit_out(hit));

  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk_in);
    wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk_in);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic logic [31:0] cfg(drive_t dr, logic ii, logic rs, logic oi, out_src_t s);
    cfg = 32'h0;
    cfg[CFG_DRIVE_LSB +: 2] = dr;
    cfg[CFG_IN_INV] = ii;
    cfg[CFG_IN_RESYNC] = rs;
    cfg[CFG_OUT_INV] = oi;
    cfg[CFG_SRC_LSB +: 2] = s;
    return cfg;
  endfunction

  function automatic logic [7:0] cfg_addr(int p);
    return CFG_BASE + 8'(4 * p);
  endfunction

  // one bench edge then let the comb outputs settle
  task automatic step();
    @(posedge ref_clk_in);
    #1;
  endtask

  task automatic t_reset();
    for (int p = 0; p < 6; p++) begin
      rd_reg(cfg_addr(p), rv);
      chk(rv, 32'h0);
      rd_reg(LEVEL_BASE + 8'(4 * p), rv);
      chk(rv, {20'h0, LEVEL_RESET});
      chk({20'h0, levels[p*12 +: 12]}, {20'h0, 12'haa4});
    end
    chk({26'h0, term}, 32'h0);
    rd_reg(STATUS_OFF, rv);
    chk({26'h0, rv[STAT_OE_LSB +: 6]}, 32'h0);
    rd_reg(8'h80, rv);
    chk(rv, 32'h0);
    $display("test reset done");
  endtask

  // input polarity and resampling, immediate vs one edge late
  task automatic t_input();
    wr_reg(cfg_addr(1), cfg(DRIVE_INPUT, 1'b1, 1'b0, 1'b0, SRC_PASS));
    step();
    chk({31'h0, xp_out[1]}, 32'h0);
    wr_reg(cfg_addr(1), cfg(DRIVE_INPUT, 1'b0, 1'b1, 1'b0, SRC_PASS));
    step();
    chk({31'h0, xp_out[1]}, 32'h1);
    @(posedge ref_clk_in);
    ext_en[1]  <= 1'b1;
    ext_val[1] <= 1'b0;
    #1 chk({31'h0, xp_out[1]}, 32'h1);
    step();
    chk({31'h0, xp_out[1]}, 32'h0);
    $display("test input chain done");
  endtask

  // push-pull pass, inverted pass and registered sources
  task automatic t_output();
    wr_reg(cfg_addr(2), cfg(DRIVE_PUSH_PULL, 1'b0, 1'b0, 1'b0, SRC_PASS));
    @(posedge ref_clk_in);
    xp_in[2] <= 1'b1;
    #1 chk({30'h0, pin_oe[2], pin_out[2]}, 32'h3);
    wr_reg(cfg_addr(2), cfg(DRIVE_PUSH_PULL, 1'b0, 1'b0, 1'b1, SRC_PASS));
    step();
    chk({31'h0, pin_out[2]}, 32'h0);
    wr_reg(cfg_addr(2), cfg(DRIVE_PUSH_PULL, 1'b0, 1'b0, 1'b0, SRC_REGISTERED));
    @(posedge ref_clk_in);
    xp_in[2] <= 1'b0;
    #1 chk({31'h0, pin_out[2]}, 32'h1);
    step();
    chk({31'h0, pin_out[2]}, 32'h0);
    $display("test output chain done");
  endtask

  task automatic count_level(input int p, input logic lv, output int c);
    c = 0;
    for (int i = 0; i < 24; i++) begin
      step();
      if (pin_out[p] === lv) c++;
    end
  endtask

  // ten-cycle pulses on rises only, inversion after generation
  task automatic t_pulse();
    int c;
    wr_reg(cfg_addr(3), cfg(DRIVE_PUSH_PULL, 1'b0, 1'b0, 1'b0, SRC_PULSE));
    @(posedge ref_clk_in);
    xp_in[3] <= 1'b1;
    count_level(3, 1'b1, c);
    chk(32'(c), 32'd10);
    @(posedge ref_clk_in);
    xp_in[3] <= 1'b0;
    count_level(3, 1'b1, c);
    chk(32'(c), 32'd0);
    wr_reg(cfg_addr(3), cfg(DRIVE_PUSH_PULL, 1'b0, 1'b0, 1'b1, SRC_PULSE));
    @(posedge ref_clk_in);
    xp_in[3] <= 1'b1;
    count_level(3, 1'b0, c);
    chk(32'(c), 32'd10);
    $display("test pulse done");
  endtask

  // clear wins over the pulse source; input drive keeps the pin released
  task automatic t_clear();
    wr_reg(cfg_addr(4), cfg(DRIVE_INPUT, 1'b0, 1'b0, 1'b1, SRC_PULSE));
    @(posedge ref_clk_in);
    xp_in[4] <= 1'b1;
    #1 chk({31'h0, pin_oe[4]}, 32'h0);
    wr_reg(ROUTE_CLEAR_OFF, 32'h1);
    rd_reg(cfg_addr(4), rv);
    chk(rv, cfg(DRIVE_INPUT, 1'b0, 1'b0, 1'b1, SRC_PASS));
    rd_reg(cfg_addr(3), rv);
    chk(rv, cfg(DRIVE_PUSH_PULL, 1'b0, 1'b0, 1'b1, SRC_PASS));
    $display("test route clear done");
  endtask

  // open drain pulls low or lets go while its input keeps watching
  task automatic t_open_drain();
    wr_reg(cfg_addr(5), cfg(DRIVE_OPEN_DRAIN, 1'b0, 1'b0, 1'b0, SRC_PASS));
    @(posedge ref_clk_in);
    xp_in[5] <= 1'b1;
    #1 chk({29'h0, pin_oe[5], pin_out[5], xp_out[5]}, 32'h1);
    @(posedge ref_clk_in);
    xp_in[5] <= 1'b0;
    #1 chk({29'h0, pin_oe[5], pin_out[5], xp_out[5]}, 32'h4);
    $display("test open drain done");
  endtask

  // sync tap from raw connector or from the first output chain
  task automatic t_tap();
    @(posedge ref_clk_in);
    ext_en[0]  <= 1'b1;
    ext_val[0] <= 1'b0;
    #1 chk({31'h0, tap}, 32'h0);
    wr_reg(TAP_CTRL_OFF, 32'h1);
    wr_reg(cfg_addr(0), cfg(DRIVE_PUSH_PULL, 1'b0, 1'b0, 1'b0, SRC_PASS));
    @(posedge ref_clk_in);
    xp_in[0] <= 1'b1;
    #1 chk({31'h0, tap}, 32'h1);
    $display("test sync tap done");
  endtask

  // status snapshot, spare codes, level and termination, then a second reset
  task automatic t_spare_reset();
    rd_reg(STATUS_OFF, rv);
    chk(rv, 32'h002d0111);
    wr_reg(LEVEL_BASE + 8'h08, 32'h0000f123);
    wr_reg(cfg_addr(5), cfg(drive_t'(2'h3), 1'b0, 1'b0, 1'b0, out_src_t'(2'h3)) | 32'h80);
    step();
    chk({30'h0, term[5], pin_oe[5]}, 32'h2);
    chk({20'h0, levels[24 +: 12]}, 32'h123);
    rd_reg(LEVEL_BASE + 8'h08, rv);
    chk(rv, 32'h123);
    rd_reg(cfg_addr(5), rv);
    chk(rv, 32'he3);
    @(posedge ref_clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    rd_reg(cfg_addr(5), rv);
    chk(rv, 32'h0);
    rd_reg(LEVEL_BASE + 8'h08, rv);
    chk(rv, {20'h0, LEVEL_RESET});
    chk({20'h0, term, pin_oe}, 32'h0);
    $display("test spare codes and reset done");
  endtask

  initial begin
    sys_rst_in = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    xp_in = 6'h00;
    ext_en = 6'h00;
    ext_val = 6'h00;
    repeat (4) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_input();
    t_output();
    t_pulse();
    t_clear();
    t_open_drain();
    t_tap();
    t_spare_reset();
    finish_test();
  end
endmodule // programmable_port_conditioning_tb_top
